// >>> logic/pss_params.svh
`ifndef PSS_PARAMS_SVH
`define PSS_PARAMS_SVH
// Notes on behaviour
// - Address, data, enables captured in input registers; read data from output register.
// - Read starts when sampled write enable high and chip enable low, whatever output enable.
// - Read data appears after the next rising edge: one cycle latency.
// - Write enable and chip enable low: store registered data at registered address.
// - Write is self-timed; no external strobe beyond registered write enable.
// - Chip enable high deselects: inputs ignored, outputs high impedance next cycle.
// - Chip enable high puts the device into standby automatically.
// - Address register loads on every rising edge regardless of operation.
// - Write enable registered every edge; low means write, high means read.
// - Registered output enable gates drivers; read with it high stays high impedance.
// - After a write the data pins stay high impedance the next cycle.
`define PSS_ADDR_W 17
`define PSS_DATA_W 9
`define PSS_DEPTH 131072
`define PSS_RD_WE_N 1'b1
`define PSS_CTRL_RST 3'h7
`endif

// >>> logic/pss_pkg.sv
package pss_pkg;
  `include "pss_params.svh"
  typedef struct packed {
    logic chipEnN;
    logic writeEnN;
    logic outputEnN;
  } pss_ctrl_t;
  typedef enum logic [1:0] {
    PSS_DESEL = 2'b00,
    PSS_READ = 2'b01,
    PSS_WRITE = 2'b10
  } pss_op_t;
endpackage

// >>> logic/pss_in_reg.sv
`timescale 1ns/1ps
module pss_in_reg #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q <= RST;
    end else begin
      q <= d;
    end
  end
endmodule

// >>> logic/pss_array.sv
`timescale 1ns/1ps
module pss_array #(
  parameter int AW = 17,
  parameter int DW = 9,
  parameter int DEPTH = 131072
) (
  input wire logic clock,
  input wire logic writeEn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];
  // Self-timed write on the same edge; no external strobe needed
  always_ff @(posedge clock) begin
    if (writeEn) begin
      mem[addr] <= wdata;
    end
  end
  assign rdata = mem[addr];
endmodule

// >>> logic/pss_sram.sv
`timescale 1ns/1ps
`include "pss_params.svh"
module pss_sram
  import pss_pkg::*;
#(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int DATA_W = `PSS_DATA_W,
  parameter int DEPTH = `PSS_DEPTH
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire pss_pkg::pss_ctrl_t ctrlIn,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOeN,
  output logic standby
);
  import pss_pkg::*;

  initial begin
    if (DEPTH > (1 << ADDR_W) || DEPTH < 1 || DATA_W < 1) begin
      $error("pss_sram: depth does not fit the address width");
    end
  end

  logic [ADDR_W-1:0] addrQ;
  logic [DATA_W-1:0] dinQ;
  logic [DATA_W-1:0] rdata;
  pss_ctrl_t ctrlQ;
  pss_op_t op;
  logic [DATA_W-1:0] dataOut_q;
  logic dataOeN_q;
  logic standby_q;

  // Input registers load on every edge, whatever the operation
  pss_in_reg #(.W(ADDR_W)) u_addr (
    .clock(clock),
    .rst(rst),
    .d(addr_in),
    .q(addrQ)
  );
  pss_in_reg #(.W(DATA_W)) u_din (
    .clock(clock),
    .rst(rst),
    .d(dataIn),
    .q(dinQ)
  );
  // Controls reset to deselected so nothing is written out of reset
  pss_in_reg #(.W(3), .RST(`PSS_CTRL_RST)) u_ctrl (
    .clock(clock),
    .rst(rst),
    .d(ctrlIn),
    .q(ctrlQ)
  );

  always_comb begin
    if (ctrlQ.chipEnN) begin
      op = PSS_DESEL;
    end else if (ctrlQ.writeEnN == `PSS_RD_WE_N) begin
      op = PSS_READ;
    end else begin
      op = PSS_WRITE;
    end
  end

  pss_array #(.AW(ADDR_W), .DW(DATA_W), .DEPTH(DEPTH)) u_mem (
    .clock(clock),
    .writeEn(op == PSS_WRITE),
    .addr(addrQ),
    .wdata(dinQ),
    .rdata(rdata)
  );

  // Output register: read data one edge after the registered request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataOut_q <= '0;
    end else if (op == PSS_READ) begin
      dataOut_q <= rdata;
    end
  end

  // Drivers enabled only for a read with output enable low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dataOeN_q <= 1'b1;
    end else begin
      dataOeN_q <= !(op == PSS_READ && !ctrlQ.outputEnN);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= ctrlQ.chipEnN;
    end
  end

  assign dataOut = dataOut_q;
  assign dataOeN = dataOeN_q;
  assign standby = standby_q;

  property p_readLatency;
    @(posedge clock) disable iff (rst)
      (op == PSS_READ && !ctrlQ.outputEnN) |=> (!dataOeN && dataOut ==
      $past(rdata));
  endproperty
  a_readLatency: assert property (p_readLatency)
    else $error("read data not presented one cycle later");

  property p_deselHiz;
    @(posedge clock) disable iff (rst)
      ctrlQ.chipEnN |=> (dataOeN && standby);
  endproperty
  a_deselHiz: assert property (p_deselHiz)
    else $error("deselected cycle drove data");

  property p_writeHiz;
    @(posedge clock) disable iff (rst)
      (!ctrlQ.chipEnN && !ctrlQ.writeEnN) |=> dataOeN;
  endproperty
  a_writeHiz: assert property (p_writeHiz)
    else $error("write cycle drove data");

  property p_oeGate;
    @(posedge clock) disable iff (rst)
      (op == PSS_READ && ctrlQ.outputEnN) |=> dataOeN;
  endproperty
  a_oeGate: assert property (p_oeGate)
    else $error("output enable high but drivers on");

  property p_addrLoad;
    @(posedge clock) disable iff (rst)
      1'b1 |=> addrQ == $past(addr_in);
  endproperty
  a_addrLoad: assert property (p_addrLoad)
    else $error("address register missed an edge");

  property p_readDecode;
    @(posedge clock) disable iff (rst)
      (ctrlIn.writeEnN && !ctrlIn.chipEnN) |=> op == PSS_READ;
  endproperty
  a_readDecode: assert property (p_readDecode)
    else $error("read not decoded");

  property p_writeDecode;
    @(posedge clock) disable iff (rst)
      (!ctrlIn.writeEnN && !ctrlIn.chipEnN) |=> op == PSS_WRITE;
  endproperty
  a_writeDecode: assert property (p_writeDecode)
    else $error("write not decoded");

  property p_writeData;
    @(posedge clock) disable iff (rst)
      op == PSS_WRITE |-> dinQ == $past(dataIn);
  endproperty
  a_writeData: assert property (p_writeData)
    else $error("write data not from input register");

  property p_standby;
    @(posedge clock) disable iff (rst)
      !ctrlQ.chipEnN |=> !standby;
  endproperty
  a_standby: assert property (p_standby)
    else $error("standby while selected");

  property p_holdOut;
    @(posedge clock) disable iff (rst)
      op != PSS_READ |=> $stable(dataOut);
  endproperty
  a_holdOut: assert property (p_holdOut)
    else $error("output register changed without read");

  // A high chip enable must win over every other control
  property p_deselOp;
    @(posedge clock) disable iff (rst)
      ctrlQ.chipEnN |->
      op == PSS_DESEL;
  endproperty
  a_deselOp: assert property (p_deselOp)
    else $error("deselect not decoded");

  // Selected with write enable high is always a read
  property p_readOp;
    @(posedge clock) disable iff (rst)
      (!ctrlQ.chipEnN && ctrlQ.writeEnN) |->
      op == PSS_READ;
  endproperty
  a_readOp: assert property (p_readOp)
    else $error("registered read not decoded");

  // Selected with write enable low is always a write
  property p_writeOp;
    @(posedge clock) disable iff (rst)
      (!ctrlQ.chipEnN && !ctrlQ.writeEnN) |->
      op == PSS_WRITE;
  endproperty
  a_writeOp: assert property (p_writeOp)
    else $error("registered write not decoded");

  // Control register follows the pins on every edge
  property p_ctrlLoad;
    @(posedge clock) disable iff (rst)
      1'b1 |=>
      ctrlQ == $past(ctrlIn);
  endproperty
  a_ctrlLoad: assert property (p_ctrlLoad)
    else $error("control register missed an edge");

  // Data input register follows the pins on every edge
  property p_dinLoad;
    @(posedge clock) disable iff (rst)
      1'b1 |=>
      dinQ == $past(dataIn);
  endproperty
  a_dinLoad: assert property (p_dinLoad)
    else $error("data register missed an edge");

  // The write goes to the address captured with the request
  property p_writeAddr;
    @(posedge clock) disable iff (rst)
      op == PSS_WRITE |->
      addrQ == $past(addr_in);
  endproperty
  a_writeAddr: assert property (p_writeAddr)
    else $error("write address not from input register");

  // Stored word is visible at once when the address is kept
  property p_writeStore;
    @(posedge clock) disable iff (rst)
      op == PSS_WRITE ##1 addrQ == $past(addrQ) |->
      rdata == $past(dinQ);
  endproperty
  a_writeStore: assert property (p_writeStore)
    else $error("write did not land on its edge");

  // Output register loads the array word for every read
  property p_readData;
    @(posedge clock) disable iff (rst)
      op == PSS_READ |=>
      dataOut == $past(rdata);
  endproperty
  a_readData: assert property (p_readData)
    else $error("read data register not loaded");

  // A write never disturbs what the pins would show
  property p_writeNoDrive;
    @(posedge clock) disable iff (rst)
      op == PSS_WRITE |=>
      (dataOeN && $stable(dataOut));
  endproperty
  a_writeNoDrive: assert property (p_writeNoDrive)
    else $error("write disturbed the data outputs");

  // Drivers may only be on in the cycle after a read
  property p_drvOnlyRead;
    @(posedge clock) disable iff (rst)
      !dataOeN |->
      $past(op) == PSS_READ;
  endproperty
  a_drvOnlyRead: assert property (p_drvOnlyRead)
    else $error("drivers on without a read");

  // Drivers need the registered output enable low
  property p_drvNeedsOe;
    @(posedge clock) disable iff (rst)
      !dataOeN |->
      !$past(ctrlQ.outputEnN);
  endproperty
  a_drvNeedsOe: assert property (p_drvNeedsOe)
    else $error("drivers on with output enable high");

  // Standby only follows a deselected cycle
  property p_standbyOnlyDesel;
    @(posedge clock) disable iff (rst)
      standby |->
      $past(ctrlQ.chipEnN);
  endproperty
  a_standbyOnlyDesel: assert property (p_standbyOnlyDesel)
    else $error("standby without deselect");

  // Deselected cycles leave the last read word in place
  property p_deselHold;
    @(posedge clock) disable iff (rst)
      op == PSS_DESEL |=>
      $stable(dataOut);
  endproperty
  a_deselHold: assert property (p_deselHold)
    else $error("deselect changed the output register");

  // A steady address keeps the address register steady
  property p_addrStable;
    @(posedge clock) disable iff (rst)
      $stable(addr_in) |=>
      $stable(addrQ);
  endproperty
  a_addrStable: assert property (p_addrStable)
    else $error("address register moved on a steady address");

  // A read with output enable high still loads but stays off the pins
  property p_readOeHigh;
    @(posedge clock) disable iff (rst)
      (op == PSS_READ && ctrlQ.outputEnN) |=>
      (dataOeN && dataOut == $past(rdata));
  endproperty
  a_readOeHigh: assert property (p_readOeHigh)
    else $error("gated read mishandled");
endmodule

// >>> tb/pss_bus_model.sv
`timescale 1ns/1ps
module pss_bus_model (
  input wire logic clock,
  input wire logic [8:0] hostData,
  input wire logic hostOeN,
  input wire logic [8:0] devData,
  input wire logic devOeN,
  output logic [8:0] busLevel
);
  // Starts known so a released bus never floats to an unknown level
  logic [8:0] last_q = 9'h000;
  // A released bus toggles every cycle so a stale value never passes
  always_comb begin
    if (!devOeN) begin
      busLevel = devData;
    end else if (!hostOeN) begin
      busLevel = hostData;
    end else begin
      busLevel = ~last_q;
    end
  end
  always_ff @(posedge clock) begin
    last_q <= busLevel;
  end
endmodule

// >>> tb/pss_sram_tb.sv
`timescale 1ns/1ps
module pss_sram_tb;
  import pss_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [16:0] addr = '0;
  pss_ctrl_t ctrl = 3'h7;
  logic [8:0] hostData = '0;
  logic hostOeN = 1'b1;
  logic [8:0] busLevel, dataOut, so;
  logic dataOeN, standby, sync_output_en_n, ssb;
  int fails = 0;
  int checked = 0;
  always #50 clock = ~clock;
  pss_sram dut (.clock(clock), .rst(rst), .addr_in(addr), .ctrlIn(ctrl),
    .dataIn(busLevel), .dataOut(dataOut), .dataOeN(dataOeN),
    .standby(standby));
  pss_bus_model bus (.clock(clock), .hostData(hostData),
    .hostOeN(hostOeN), .devData(dataOut), .devOeN(dataOeN),
    .busLevel(busLevel));
  // Samples taken here show the result of the op issued two calls back
  task automatic op(logic ce, logic we, logic oe, logic [16:0] a,
      logic [8:0] d);
    @(posedge clock);
    ctrl <= '{ce, we, oe};
    addr <= a;
    hostData <= d;
    hostOeN <= ce | we;
    #1;
    {ssb, sync_output_en_n, so} = {standby, dataOeN, dataOut};
  endtask
  task automatic check(logic [10:0] seen, logic [10:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic s_rw;
    op(0, 0, 1, 17'h00000, 9'h1a5);
    op(0, 0, 1, 17'h1ffff, 9'h05a);
    op(0, 1, 0, 17'h00000, 9'h000);
    check(sync_output_en_n, 1'b1);
    op(0, 1, 0, 17'h1ffff, 9'h000);
    check(sync_output_en_n, 1'b1);
    op(1, 1, 1, 17'h00000, 9'h000);
    check({sync_output_en_n, so}, {1'b0, 9'h1a5});
    op(1, 1, 1, 17'h00000, 9'h000);
    check({sync_output_en_n, so}, {1'b0, 9'h05a});
  endtask
  task automatic s_desel;
    op(1, 0, 0, 17'h00000, 9'h0ff);
    op(1, 1, 1, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    check({ssb, sync_output_en_n}, 2'b11);
    op(0, 1, 0, 17'h00000, 9'h000);
    op(0, 1, 0, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    check({ssb, sync_output_en_n, so}, {2'b00, 9'h1a5});
  endtask
  task automatic s_oe;
    op(0, 1, 1, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    check(sync_output_en_n, 1'b1);
    op(1, 1, 1, 17'h00000, 9'h000);
    op(0, 0, 1, 17'h00000, 9'h033);
    op(0, 1, 0, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    op(1, 1, 1, 17'h00000, 9'h000);
    check({sync_output_en_n, so}, {1'b0, 9'h033});
  endtask
  task automatic give_verdict;
    if (fails == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    s_rw;
    s_desel;
    s_oe;
    give_verdict;
  end
endmodule
